// [hdl/err_word_enc.sv]
/*
  Module error word encoder with its configuration registers,
  classic Wishbone slave and interrupt logic.
  Assumes all inputs synchronous to CLK; fault inputs are levels.
  Assumes one request at a time, answered one cycle after it is
  taken; a rejected configuration write is still acknowledged.
  Assumes software leaves the power-up state by setting the run bit.
*/
`timescale 1ns/1ps
`include "err_word_map.svh"
module err_word_enc
  import err_word_pkg::*;
#(
  parameter int CHANNELS = 6
)(
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire wb_req_s       WB_REQ,
  output wb_rsp_s            WB_RSP,
  input  wire hw_fault_s     HW_FAULT,
  output logic [15:0]        ERR_WORD,
  output ch_cfg_s [5:0]      CH_CFG,
  output logic [15:0]        CAL_EN,
  output logic               IRQ
);

  ////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int HW_N  = 17;
  localparam int CFG_N = 20;

  // State and its next value
  enc_state_s                 s;
  enc_state_s                 next_s;

  // Cause vectors and search results
  logic [HW_N-1:0]            hw_vec;
  logic                       hw_found;
  logic [$clog2(HW_N)-1:0]    hw_idx;
  logic                       cfg_found;
  logic [$clog2(CFG_N)-1:0]   cfg_idx;
  logic [8:0]                 hw_ext;

  // Bus decode and channel candidate
  logic                       take;
  logic                       is_ch;
  logic [7:0]                 ch_off;
  logic [2:0]                 ch;
  ch_cfg_s                    cand;

  // Candidate field checks
  logic                       filt_bad;
  logic                       fmt_bad;
  logic                       exc_bad;
  logic                       rsv_bad;

  // Calibration candidate and events of the cycle
  logic [15:0]                cal_cand;
  logic [CFG_N-1:0]           cfg_set;
  logic                       cfg_clr;
  logic                       cfg_rej;
  logic                       rd_clear;
  logic                       hw_rise;
  logic [1:0]                 irq_next;

  ////////////////////////////////////////////////////////////////////
  // Cause vectors and priority search

  // Hardware causes in code order
  assign hw_vec = {HW_FAULT.adc,
                   HW_FAULT.cal,
                   HW_FAULT.eeprom,
                   HW_FAULT.rom,
                   HW_FAULT.supply_loss,
                   ~s.run,
                   HW_FAULT.general};

  // Lowest hardware code wins
  lowest_set #(
    .W     (HW_N)
  ) u_hw_pick (
    .vec   (hw_vec),
    .found (hw_found),
    .idx   (hw_idx)
  );

  // Lowest configuration code wins
  lowest_set #(
    .W     (CFG_N)
  ) u_cfg_pick (
    .vec   (s.cfg_err),
    .found (cfg_found),
    .idx   (cfg_idx)
  );

  // Extended code of the chosen hardware cause
  always_comb
  begin
    if (hw_idx < 5'd2)
    begin
      hw_ext = {4'h0, hw_idx};
    end
    else
    begin
      hw_ext = `EW_EXT_SPEC + {4'h0, hw_idx - 5'd2};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Address decode and candidate configuration

  // Channel register window
  assign take   = WB_REQ.cyc && WB_REQ.stb && !s.ack;
  assign ch_off = WB_REQ.adr - `EW_OFF_CH0;
  assign ch     = ch_off[4:2];
  assign is_ch  = (WB_REQ.adr >= `EW_OFF_CH0) && (WB_REQ.adr <= `EW_OFF_CH_LAST)
                  && (WB_REQ.adr[1:0] == 2'b00);

  // Byte-lane merge into the addressed channel word
  always_comb
  begin
    cand = '0;
    if (is_ch)
    begin
      cand = s.cfg[ch]; // Only in-window indexes are read
    end
    if (WB_REQ.sel[0])
    begin
      cand[7:0] = WB_REQ.dat[7:0];
    end
    if (WB_REQ.sel[1])
    begin
      cand[15:8] = WB_REQ.dat[15:8];
    end
  end

  // Byte-lane merge into the calibration enable word
  always_comb
  begin
    cal_cand = s.cal_en;
    if (WB_REQ.sel[0])
    begin
      cal_cand[7:0] = WB_REQ.dat[7:0];
    end
    if (WB_REQ.sel[1])
    begin
      cal_cand[15:8] = WB_REQ.dat[15:8];
    end
  end

  // Field checks of the candidate
  cfg_check u_check (
    .cfg      (cand),
    .filt_bad (filt_bad),
    .fmt_bad  (fmt_bad),
    .exc_bad  (exc_bad),
    .rsv_bad  (rsv_bad)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state

  // Bus access, validation, flags and status word
  always_comb
  begin
    next_s   = s;
    cfg_set  = '0;
    cfg_clr  = 1'b0;
    cfg_rej  = 1'b0;
    rd_clear = 1'b0;

    // Ack and read data stand one cycle
    next_s.ack  = take;
    next_s.rdat = 32'h0000_0000;

    // Read data, unmapped reads as zero
    if (take && !WB_REQ.we)
    begin
      if (is_ch)
      begin
        next_s.rdat = {16'h0000, s.cfg[ch]};
      end
      else
      begin
        case (WB_REQ.adr)
          `EW_OFF_WORD:     next_s.rdat = {16'h0000, s.word};
          `EW_OFF_CTRL:     next_s.rdat = {31'h0000_0000, s.run};
          `EW_OFF_CALEN:    next_s.rdat = {16'h0000, s.cal_en};
          `EW_OFF_IRQ_STAT:
          begin
            next_s.rdat = {30'h0000_0000, s.irq_stat};
            rd_clear    = 1'b1;
          end
          `EW_OFF_IRQ_MASK: next_s.rdat = {30'h0000_0000, s.irq_mask};
          default:          next_s.rdat = 32'h0000_0000;
        endcase
      end
    end

    // Writes; unmapped and read-only writes are ignored
    if (take && WB_REQ.we)
    begin
      if (is_ch)
      begin
        if (filt_bad || fmt_bad || exc_bad || rsv_bad)
        begin
          cfg_rej              = 1'b1;
          cfg_set[0]           = rsv_bad;
          cfg_set[1 + ch]      = filt_bad;
          cfg_set[7 + ch]      = fmt_bad;
          cfg_set[13 + ch]     = exc_bad;
        end
        else
        begin
          next_s.cfg[ch] = cand;
        end
      end
      else
      begin
        case (WB_REQ.adr)
          `EW_OFF_CTRL:
          begin
            if (WB_REQ.sel[0])
            begin
              next_s.run = WB_REQ.dat[`EW_CTRL_RUN_BIT];
              cfg_clr    = WB_REQ.dat[`EW_CTRL_CLR_BIT];
            end
          end
          `EW_OFF_CALEN:
          begin
            if ((cal_cand & ~`EW_CALEN_MASK) != 16'h0000)
            begin
              cfg_rej     = 1'b1;
              cfg_set[19] = 1'b1;
            end
            else
            begin
              next_s.cal_en = cal_cand;
            end
          end
          `EW_OFF_IRQ_MASK:
          begin
            if (WB_REQ.sel[0])
            begin
              next_s.irq_mask = WB_REQ.dat[1:0];
            end
          end
          default:
          begin
            next_s.cal_en = s.cal_en;
          end
        endcase
      end
    end

    // Sticky config causes, a new cause beats the clear
    // Clear comes from the control register bit
    next_s.cfg_err = (cfg_clr ? '0 : s.cfg_err) | cfg_set;

    // Entry into the hardware class
    hw_rise        = hw_found && !s.hw_seen;
    next_s.hw_seen = hw_found;

    // Sticky events, read clears, a new event beats the read
    irq_next = rd_clear ? 2'b00 : s.irq_stat;
    irq_next[`EW_IRQ_HW_BIT]  = irq_next[`EW_IRQ_HW_BIT] | hw_rise;
    irq_next[`EW_IRQ_CFG_BIT] = irq_next[`EW_IRQ_CFG_BIT] | cfg_rej;
    next_s.irq_stat = irq_next;
    next_s.irq      = |(irq_next & next_s.irq_mask);

    // Status word, hardware class first
    if (hw_found)
    begin
      next_s.word = {`EW_DONT_CARE, `EW_CLASS_HW, hw_ext};
    end
    else if (cfg_found)
    begin
      next_s.word = {`EW_DONT_CARE, `EW_CLASS_CFG, 4'h0, cfg_idx};
    end
    else
    begin
      next_s.word = {`EW_DONT_CARE, `EW_CLASS_NONE, `EW_EXT_NONE};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  // Reset to the power-up state
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      // Every channel word back to its reset value
      for (int i = 0; i < CHANNELS; i++)
      begin
        s.cfg[i] <= `EW_CH_CFG_RST;
      end
      s.cal_en   <= `EW_CALEN_RST;
      s.run      <= 1'b0;
      s.cfg_err  <= '0;
      s.hw_seen  <= 1'b1;
      s.irq_stat <= 2'b00;
      s.irq_mask <= `EW_IRQ_MASK_RST;
      s.word     <= `EW_WORD_RST;
      s.irq      <= 1'b0;
      s.ack      <= 1'b0;
      s.rdat     <= 32'h0000_0000;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register

  // Bus answer
  assign WB_RSP.ack = s.ack;
  assign WB_RSP.dat = s.rdat;

  // Word, accepted settings and interrupt
  assign ERR_WORD   = s.word;
  assign CH_CFG     = s.cfg;
  assign CAL_EN     = s.cal_en;
  assign IRQ        = s.irq;

endmodule // err_word_enc

// [common/err_word_map.svh]
/*
  Register offsets, field codes, reset values and limits of the
  module error word encoder.
  Assumes a byte-addressed 32-bit classic Wishbone slave port.
*/
`ifndef ERR_WORD_MAP_SVH
`define ERR_WORD_MAP_SVH

// Register byte offsets
`define EW_OFF_WORD      8'h00
`define EW_OFF_CTRL      8'h04
`define EW_OFF_CALEN     8'h08
`define EW_OFF_CH0       8'h0C
`define EW_OFF_CH_LAST   8'h20
`define EW_OFF_IRQ_STAT  8'h24
`define EW_OFF_IRQ_MASK  8'h28

// Control register bit positions
`define EW_CTRL_RUN_BIT  0
`define EW_CTRL_CLR_BIT  1

// Error class codes, word bits 11..9
`define EW_CLASS_NONE    3'b000
`define EW_CLASS_HW      3'b001
`define EW_CLASS_CFG     3'b010

// Extended code base of hardware-specific causes
`define EW_EXT_SPEC      9'h100
`define EW_EXT_NONE      9'h000
`define EW_DONT_CARE     4'h0

// Interrupt status bit positions
`define EW_IRQ_HW_BIT    0
`define EW_IRQ_CFG_BIT   1

// Validity limits of configuration fields
`define EW_FILT_COUNT    3'h6
`define EW_FMT_COUNT     3'h6
`define EW_EXC_HI_RANGE  4'h8
`define EW_CALEN_MASK    16'h003F

// Reset values
`define EW_CH_CFG_RST    16'h0000
`define EW_CALEN_RST     16'h0000
`define EW_IRQ_MASK_RST  2'h0
`define EW_WORD_RST      16'h0201

`endif

// [common/err_word_pkg.sv]
/*
  Types of the module error word encoder: bus carriers, channel
  configuration layout, fault inputs and the encoder state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package err_word_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  // Classic Wishbone answer to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  // One channel configuration word
  typedef struct packed {
    logic [2:0] rsv;
    logic       excite;
    logic [3:0] range;
    logic       pad1;
    logic [2:0] format;
    logic       pad0;
    logic [2:0] filter;
  } ch_cfg_s;

  // Hardware fault levels
  typedef struct packed {
    logic       general;
    logic       supply_loss;
    logic       rom;
    logic       eeprom;
    logic [5:0] cal;
    logic [5:0] adc;
  } hw_fault_s;

  // Whole state of the encoder
  typedef struct packed {
    ch_cfg_s [5:0] cfg;
    logic [15:0]   cal_en;
    logic          run;
    logic [19:0]   cfg_err;
    logic          hw_seen;
    logic [1:0]    irq_stat;
    logic [1:0]    irq_mask;
    logic [15:0]   word;
    logic          irq;
    logic          ack;
    logic [31:0]   rdat;
  } enc_state_s;

endpackage

// [hdl/lowest_set.sv]
/*
  Finds the lowest set bit of a vector.
  Assumes a purely combinational use; no clock.
*/
`timescale 1ns/1ps
module lowest_set
  import err_word_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic [W-1:0]         vec,
  output logic                      found,
  output logic [$clog2(W)-1:0]      idx
);

  // Scan from the top so the lowest set bit wins
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (vec[i])
      begin
        found = 1'b1;
        idx   = ($clog2(W))'(i);
      end
    end
  end

endmodule // lowest_set

// [hdl/cfg_check.sv]
/*
  Validity checks of one channel configuration word.
  Assumes the word is a candidate not yet accepted.
*/
`timescale 1ns/1ps
`include "err_word_map.svh"
module cfg_check
  import err_word_pkg::*;
(
  input  wire ch_cfg_s cfg,
  output logic         filt_bad,
  output logic         fmt_bad,
  output logic         exc_bad,
  output logic         rsv_bad
);

  // Unsupported codes and a weak current on a high range
  always_comb
  begin
    filt_bad = cfg.filter >= `EW_FILT_COUNT;
    fmt_bad  = cfg.format >= `EW_FMT_COUNT;
    exc_bad  = cfg.excite && (cfg.range >= `EW_EXC_HI_RANGE);
    rsv_bad  = (cfg.rsv != 3'h0) || cfg.pad1 || cfg.pad0;
  end

endmodule // cfg_check

// [sim/err_word_enc_assertions.sv]
/*
  Port assertions of the error word encoder.
  Bound to every err_word_enc instance; one clock domain.
*/
`timescale 1ns/1ps
module err_word_enc_assertions
  import err_word_pkg::*;
(
  input wire logic          CLK,
  input wire logic          RST_N,
  input wire wb_req_s       WB_REQ,
  input wire wb_rsp_s       WB_RSP,
  input wire hw_fault_s     HW_FAULT,
  input wire logic [15:0]   ERR_WORD,
  input wire ch_cfg_s [5:0] CH_CFG,
  input wire logic [15:0]   CAL_EN,
  input wire logic          IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Word fields
  logic [2:0] cls;
  logic [8:0] ext;
  assign cls = ERR_WORD[11:9];
  assign ext = ERR_WORD[8:0];

  // Request taken, answered for one cycle
  sequence taken_s;
    WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
  endsequence
  sequence answer_s;
    WB_RSP.ack ##1 !WB_RSP.ack;
  endsequence

  ack_answer_a: assert property (taken_s |=> answer_s)
    else $error("ack not a one cycle answer");
  top_nibble_a: assert property (ERR_WORD[15:12] == 4'h0)
    else $error("top nibble not zero");
  class_legal_a: assert property (cls inside {3'b000, 3'b001, 3'b010})
    else $error("illegal class");
  none_ext_a: assert property (cls == 3'b000 |-> ext == 9'h000)
    else $error("extended bits set with no error");
  general_code_a: assert property (HW_FAULT.general |=> ERR_WORD[11:0] == 12'h200)
    else $error("general fault code wrong");
  hw_beats_a: assert property (HW_FAULT != '0 |=> cls == 3'b001)
    else $error("hardware fault not in hardware class");
  idle_hw_a: assert property (HW_FAULT == '0 |=> cls != 3'b001 || ext == 9'h001)
    else $error("hardware class without fault");
  hw_range_a: assert property (cls == 3'b001 |-> ext <= 9'h001 ||
    (ext >= 9'h100 && ext <= 9'h10E)) else $error("hardware code out of range");
  cfg_range_a: assert property (cls == 3'b010 |-> ext <= 9'h013)
    else $error("config code out of range");
endmodule // err_word_enc_assertions

bind err_word_enc err_word_enc_assertions i_chk (.CLK(CLK), .RST_N(RST_N),
  .WB_REQ(WB_REQ), .WB_RSP(WB_RSP), .HW_FAULT(HW_FAULT), .ERR_WORD(ERR_WORD),
  .CH_CFG(CH_CFG), .CAL_EN(CAL_EN), .IRQ(IRQ));

// [sim/status_reader.sv]
/*
  Host controller model that reads the module error word.
  Assumes the word is synchronous to clk.
*/
`timescale 1ns/1ps
module status_reader
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] word,
  output logic [2:0]       cls,
  output logic [8:0]       cause
);
  // Cause looked at only for a non-zero class
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cls <= 3'h0;
      cause <= 9'h000;
    end
    else
    begin
      cls <= word[11:9];
      cause <= (word[11:9] != 3'b000) ? word[8:0] : 9'h000;
    end
endmodule // status_reader

// [sim/test_err_word_enc.sv]
/*
  Self-checking bench of the error word encoder.
  Drives Wishbone and fault inputs; a host model reads the word.
*/
`timescale 1ns/1ps
`include "err_word_map.svh"
module test_err_word_enc;
  import err_word_pkg::*;
  logic          clk, rst_n, irq;
  wb_req_s       req;
  wb_rsp_s       rsp;
  hw_fault_s     fault;
  logic [15:0]   word, cal_en;
  ch_cfg_s [5:0] ch_cfg;
  logic [2:0]    rd_cls;
  logic [8:0]    rd_cause;
  logic [31:0]   q;
  int            fails, check_count;

  err_word_enc #(.CHANNELS(6)) i_dut (.CLK(clk), .RST_N(rst_n), .WB_REQ(req),
    .WB_RSP(rsp), .HW_FAULT(fault), .ERR_WORD(word), .CH_CFG(ch_cfg),
    .CAL_EN(cal_en), .IRQ(irq));
  status_reader i_host (.clk(clk), .rst_n(rst_n), .word(word), .cls(rd_cls),
    .cause(rd_cause));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Verdict
  task summarize;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compare one value
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // Classic single cycle, waits for ack
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do
    begin
      @(posedge clk);
    end while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask

  task wait_n(input int k);
    repeat (k) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Power-up word, read-only word, unmapped place
  task t_reset;
    chk("reset word", 32'h0000_0201, {16'h0, word});
    wb(1'b0, `EW_OFF_WORD, 32'h0);
    chk("word read", 32'h0000_0201, q);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped read", 32'h0, q);
    wb(1'b1, `EW_OFF_CTRL, 32'h1);
    wb(1'b1, `EW_OFF_WORD, 32'h0000_FFFF);
    wait_n(3);
    chk("idle word", 32'h0, {16'h0, word});
    chk("host idle", 32'h0, {20'h0, rd_cls, rd_cause});
  endtask

  // Every hardware fault input, then priority
  task t_hw;
    logic [11:0] e;
    for (int i = 0; i < 16; i++)
    begin
      // General, supply, ROM, EEPROM, then cal 0..5, then converter 0..5
      if (i < 4)
        fault <= hw_fault_s'(16'h8000 >> i);
      else if (i < 10)
        fault <= hw_fault_s'(16'h0040 << (i - 4));
      else
        fault <= hw_fault_s'(16'h0001 << (i - 10));
      e = (i == 0) ? 12'h200 : 12'(12'h2FF + i);
      wait_n(3);
      chk("hw code", {20'h0, e}, {16'h0, word});
      chk("host class", 32'h1, {29'h0, rd_cls});
      chk("host cause", {23'h0, e[8:0]}, {23'h0, rd_cause});
    end
    fault <= hw_fault_s'(16'h0102);
    wait_n(3);
    chk("lowest code", 32'h305, {16'h0, word});
    fault <= '1;
    wait_n(3);
    chk("general first", 32'h200, {16'h0, word});
  endtask

  // Interrupt masked, raised, cleared by read
  task t_irq;
    fault <= '0;
    wb(1'b1, `EW_OFF_IRQ_MASK, 32'h0);
    wb(1'b0, `EW_OFF_IRQ_STAT, 32'h0);
    fault <= hw_fault_s'(16'h4000);
    wait_n(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b1, `EW_OFF_IRQ_MASK, 32'h1);
    wait_n(3);
    chk("irq raised", 32'h1, {31'h0, irq});
    wb(1'b0, `EW_OFF_IRQ_STAT, 32'h0);
    chk("irq status", 32'h1, q);
    wait_n(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    fault <= '0;
    wait_n(3);
  endtask

  // Invalid settings rejected and coded, valid ones kept
  task t_cfg;
    logic [15:0] p;
    for (int n = 0; n < 6; n++)
      for (int k = 0; k < 3; k++)
      begin
        p = (k == 0) ? 16'h0006 : (k == 1) ? 16'h0060 : 16'h1800;
        wb(1'b1, 8'h0C + 8'(4 * n), {16'h0, p});
        wait_n(3);
        chk("cfg code", 32'h400 + 32'(1 + 6 * k + n), {16'h0, word});
        chk("cfg kept", 32'h0, {16'h0, ch_cfg[n]});
        wb(1'b1, `EW_OFF_CTRL, 32'h3);
      end
    wb(1'b1, 8'h18, 32'h0080);
    wait_n(3);
    chk("general cfg", 32'h400, {16'h0, word});
    wb(1'b0, `EW_OFF_IRQ_STAT, 32'h0);
    chk("cfg status", 32'h2, q);
    wb(1'b1, `EW_OFF_CTRL, 32'h3);
    wb(1'b1, `EW_OFF_CALEN, 32'h0040);
    wait_n(3);
    chk("calen code", 32'h413, {16'h0, word});
    chk("calen kept", 32'h0, {16'h0, cal_en});
    wb(1'b1, `EW_OFF_CTRL, 32'h3);
    wb(1'b1, 8'h20, 32'h0105);
    wb(1'b1, `EW_OFF_CALEN, 32'h003F);
    wait_n(3);
    chk("cfg stored", 32'h0105, {16'h0, ch_cfg[5]});
    chk("calen stored", 32'h003F, {16'h0, cal_en});
    chk("clean word", 32'h0, {16'h0, word});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    fault = '0;
    fails = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_hw;
    t_irq;
    t_cfg;
    summarize;
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule // test_err_word_enc
